/* File: src/dacrp_consts.svh */
`ifndef DACRP_CONSTS_SVH
`define DACRP_CONSTS_SVH
// result width and msb position
`define DACRP_RES_W 14
`define DACRP_RES_MSB 13
// clock rate in kHz
`define DACRP_CLK_KHZ 25000
// conversion time, high sampling mode, in ns
`define DACRP_CONV_HS_NS 5200
// conversion time, auto sleep mode, in ns
`define DACRP_CONV_AS_NS 10000
// cycles: longest times round down
`define DACRP_CONV_HS_CYC ((`DACRP_CONV_HS_NS * `DACRP_CLK_KHZ) / 1000000)
`define DACRP_CONV_AS_CYC ((`DACRP_CONV_AS_NS * `DACRP_CLK_KHZ) / 1000000)
// counter width
`define DACRP_CNT_W 10
`define DACRP_ONE 10'h001
`define DACRP_ZERO14 14'h0000
`define DACRP_MID14 14'h2000
`endif

/* File: src/dacrp_pkg.sv */
package dacrp_pkg;
  typedef enum logic [1:0] {
    DACRP_IDLE = 2'b00,
    DACRP_CONV = 2'b01
  } dacrp_state_t;
  // which stored result the next read returns
  typedef enum logic {
    DACRP_RD_FIRST = 1'b0,
    DACRP_RD_SECOND = 1'b1
  } dacrp_order_t;
endpackage

/* File: src/dacrp_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for one asynchronous pin
module dacrp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic synced
);
  logic meta_q;
  // first flop is read only by the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= RST_VAL;
      synced <= RST_VAL;
    end else begin
      meta_q <= pin;
      synced <= meta_q;
    end
  end
endmodule

/* File: src/dacrp_top.sv */
`timescale 1ns/1ps
`include "dacrp_consts.svh"
// ==========================================================
// conversion control and read port
module dacrp_top import dacrp_pkg::*; #(
  parameter int RES_W = `DACRP_RES_W,
  parameter logic UNIPOLAR = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic auto_sleep,
  input wire logic conversion_start_n,
  input wire logic pair_select,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic [RES_W-1:0] input_a_first,
  input wire logic [RES_W-1:0] input_a_second,
  input wire logic [RES_W-1:0] input_b_first,
  input wire logic [RES_W-1:0] input_b_second,
  output logic busy,
  output logic [RES_W-1:0] result_bus_o,
  output logic [RES_W-1:0] result_bus_oe,
  output logic [1:0] held_pair
);
  // ==========================================================
  // parameter checks
  // the store, the coding mask and the bus constants are all fourteen wide
  initial begin
    if (RES_W != `DACRP_RES_W) begin
      $error("result width must be fourteen");
    end
    // the longer conversion count must fit the down counter
    if (`DACRP_CONV_AS_CYC >= (1 << `DACRP_CNT_W)) begin
      $error("conversion count does not fit the counter");
    end
    if (`DACRP_CONV_HS_CYC < 2) begin
      $error("conversion count too short for the sequencer");
    end
  end

  localparam logic [`DACRP_CNT_W-1:0] CONV_HS =
    `DACRP_CNT_W'(`DACRP_CONV_HS_CYC);
  localparam logic [`DACRP_CNT_W-1:0] CONV_AS =
    `DACRP_CNT_W'(`DACRP_CONV_AS_CYC);

  // ==========================================================
  // pin synchronisers
  // reset values match the idle level of each pin, so no false edge
  // follows reset; the cost is two cycles of lag on every host action
  logic start_n_s, sel_s, cs_n_s, rd_n_s, sleep_s;
  dacrp_sync #(.RST_VAL(1'b1)) u_start (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(conversion_start_n),
    .synced(start_n_s)
  );
  dacrp_sync #(.RST_VAL(1'b0)) u_sel (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(pair_select),
    .synced(sel_s)
  );
  dacrp_sync #(.RST_VAL(1'b1)) u_cs (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(chip_select_n),
    .synced(cs_n_s)
  );
  dacrp_sync #(.RST_VAL(1'b1)) u_rd (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(read_n),
    .synced(rd_n_s)
  );
  dacrp_sync #(.RST_VAL(1'b0)) u_sleep (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(auto_sleep),
    .synced(sleep_s)
  );

  // ==========================================================
  // edge detection on synced levels
  logic start_n_q, read_q;
  logic start_fall, read_active, read_rise;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_n_q <= 1'b1;
      read_q <= 1'b0;
    end else begin
      start_n_q <= start_n_s;
      read_q <= read_active;
    end
  end
  assign start_fall = start_n_q & ~start_n_s;
  assign read_active = ~cs_n_s & ~rd_n_s;
  assign read_rise = read_q & ~read_active;

  // ==========================================================
  // conversion sequencer
  dacrp_state_t state_q;
  logic [`DACRP_CNT_W-1:0] cnt_q;
  logic sel_q;
  logic [RES_W-1:0] samp_first_q, samp_second_q;
  logic done;
  assign done = (state_q == DACRP_CONV) && (cnt_q == `DACRP_ONE);

  // start holds both inputs of the chosen pair at once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= 1'b0;
      samp_first_q <= `DACRP_ZERO14;
      samp_second_q <= `DACRP_ZERO14;
    end else if (start_fall && state_q == DACRP_IDLE) begin
      sel_q <= sel_s;
      samp_first_q <= sel_s ? input_b_first : input_a_first;
      samp_second_q <= sel_s ? input_b_second : input_a_second;
    end
  end

  // starts during a conversion are ignored; a real part cannot take them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= DACRP_IDLE;
      cnt_q <= `DACRP_ONE;
    end else begin
      unique case (state_q)
        DACRP_IDLE: begin
          if (start_fall) begin
            state_q <= DACRP_CONV;
            cnt_q <= sleep_s ? CONV_AS : CONV_HS;
          end
        end
        DACRP_CONV: begin
          if (done) begin
            state_q <= DACRP_IDLE;
          end else begin
            cnt_q <= cnt_q - `DACRP_ONE;
          end
        end
        default: begin
          state_q <= DACRP_IDLE;
        end
      endcase
    end
  end

  // busy rises with the start and falls at the end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (start_fall && state_q == DACRP_IDLE) begin
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;
    end
  end

  // ==========================================================
  // result store: coding per range variant
  logic [RES_W-1:0] res_first_q, res_second_q;
  function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] s);
    // samples arrive offset binary; bipolar flips msb
    code = UNIPOLAR ? s : (s ^ `DACRP_MID14);
  endfunction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_first_q <= `DACRP_ZERO14;
      res_second_q <= `DACRP_ZERO14;
    end else if (done) begin
      res_first_q <= code(samp_first_q);
      res_second_q <= code(samp_second_q);
    end
  end

  // ==========================================================
  // read order: advances at the end of each read
  dacrp_order_t order_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      order_q <= DACRP_RD_FIRST;
    end else if (start_fall && state_q == DACRP_IDLE) begin
      order_q <= DACRP_RD_FIRST;
    end else if (read_rise) begin
      order_q <= (order_q == DACRP_RD_FIRST) ? DACRP_RD_SECOND
                                              : DACRP_RD_FIRST;
    end
  end

  // ==========================================================
  // bus drive; reads during conversion return old data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_bus_o <= `DACRP_ZERO14;
      result_bus_oe <= `DACRP_ZERO14;
    end else if (read_active) begin
      result_bus_o <= (order_q == DACRP_RD_FIRST) ? res_first_q
                                                  : res_second_q;
      result_bus_oe <= ~`DACRP_ZERO14;
    end else begin
      result_bus_oe <= `DACRP_ZERO14;
    end
  end

  // held pair shown for the host's benefit: bit1 valid, bit0 pair
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      held_pair <= 2'b00;
    end else if (done) begin
      held_pair <= {1'b1, sel_q};
    end
  end
endmodule

/* File: verification/dacrp_host.sv */
`timescale 1ns/1ps
// ====================
// host model
module dacrp_host (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic [13:0] result_bus_o,
  input wire logic [13:0] result_bus_oe,
  output logic conversion_start_n,
  output logic pair_select,
  output logic auto_sleep,
  output logic chip_select_n,
  output logic read_n,
  output logic timed_out
);
  logic [13:0] last_q = 14'h0000;
  logic [13:0] bus;
  // released lines show the inverse of the last value, never a held copy
  assign bus = (result_bus_o & result_bus_oe) | (~last_q & ~result_bus_oe);
  always @(posedge clk_sys) last_q <= bus;
  initial begin
    {conversion_start_n, chip_select_n, read_n} = 3'b111;
    {pair_select, auto_sleep, timed_out} = 3'b000;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 400 && busy !== lvl; i++) step(1);
    if (busy !== lvl) timed_out = 1'b1;
  endtask
  // pair is set first, then acquisition and quiet time pass before start
  task automatic convert(input logic pair, input logic sleep);
    wait_busy(1'b0);
    pair_select = pair;
    auto_sleep = sleep;
    step(13);
    conversion_start_n = 1'b0;
    step(2);
    conversion_start_n = 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  task automatic read_word(input logic sel_n, output logic [13:0] d,
      output logic [13:0] en);
    chip_select_n = sel_n;
    read_n = 1'b0;
    for (int i = 0; i < 8 && (&result_bus_oe) !== 1'b1; i++) step(1);
    d = bus;
    en = result_bus_oe;
    if (!sel_n && en !== 14'h3fff) timed_out = 1'b1;
    {read_n, chip_select_n} = 2'b11;
    for (int i = 0; i < 8 && result_bus_oe !== 14'h0000; i++) step(1);
    step(1);
  endtask
endmodule

/* File: verification/dacrp_monitor.sv */
`timescale 1ns/1ps
// ====================
// port checks
module dacrp_monitor #(
  parameter int RES_W = 14
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic auto_sleep,
  input wire logic conversion_start_n,
  input wire logic pair_select,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic busy,
  input wire logic [RES_W-1:0] result_bus_oe,
  input wire logic [1:0] held_pair
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a start only counts while idle; busy starts are refused silently
  sequence s_start;
    $fell(conversion_start_n) && !busy;
  endsequence
  // four idle samples cover the three-cycle pin lag
  sequence s_unsel;
    chip_select_n [*4];
  endsequence
  a_busy_rise: assert property (
    s_start |-> ##[1:4] busy)
    else $error("busy late");
  a_fast_conv: assert property (
    $rose(busy) && !auto_sleep |-> ##129 busy ##1 !busy)
    else $error("fast conversion length");
  a_sleep_conv: assert property (
    $rose(busy) && auto_sleep |-> ##249 busy ##1 !busy)
    else $error("sleep conversion length");
  a_unsel_quiet: assert property (
    s_unsel |-> result_bus_oe == '0)
    else $error("bus driven unselected");
  a_rd_quiet: assert property (
    read_n [*4] |-> result_bus_oe == '0)
    else $error("bus driven without read");
  a_bus_whole: assert property (
    result_bus_oe == '0 || &result_bus_oe)
    else $error("partial bus drive");
  a_read_drives: assert property (
    (!chip_select_n && !read_n) [*4] |-> &result_bus_oe)
    else $error("read not driven");
  a_pair_held: assert property (
    $fell(busy) |-> ##[0:1] held_pair == {1'b1, pair_select})
    else $error("wrong pair held");
endmodule
bind dacrp_top dacrp_monitor #(.RES_W(RES_W)) dacrp_monitor_i (.clk_sys, .rst,
  .auto_sleep, .conversion_start_n, .pair_select, .chip_select_n, .read_n,
  .busy, .result_bus_oe, .held_pair);

/* File: verification/dual_adc_conversion_read_port_test.sv */
`timescale 1ns/1ps
module dual_adc_conversion_read_port_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [13:0] input_a_first, input_a_second, input_b_first, input_b_second;
  logic auto_sleep, conversion_start_n, pair_select, chip_select_n, read_n;
  logic busy, timed_out;
  logic [13:0] result_bus_o, result_bus_oe;
  logic [1:0] held_pair;
  int err_count = 0;
  int checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  dacrp_top dacrp_top_i (.clk_sys, .rst, .auto_sleep, .conversion_start_n,
    .pair_select, .chip_select_n, .read_n, .input_a_first, .input_a_second,
    .input_b_first, .input_b_second, .busy, .result_bus_o, .result_bus_oe,
    .held_pair);
  dacrp_host dacrp_host_i (.clk_sys, .busy, .result_bus_o, .result_bus_oe,
    .conversion_start_n, .pair_select, .auto_sleep, .chip_select_n, .read_n,
    .timed_out);
  // bipolar build: offset binary sample with msb flipped
  function automatic logic [13:0] coded(input logic [13:0] x);
    return x ^ 14'h2000;
  endfunction
  task automatic tally_and_finish();
    if (timed_out) err_count++;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
    if (timed_out) tally_and_finish();
  endtask
  // reads return first, second, then wrap; other pair holds decoys
  task automatic s_pair_order(input logic pair, input logic sleep,
      input logic [13:0] f, input logic [13:0] s);
    logic [13:0] d, en;
    {input_a_first, input_a_second, input_b_first, input_b_second} =
      pair ? {~f, ~s, f, s} : {f, s, ~f, ~s};
    dacrp_host_i.convert(pair, sleep);
    dacrp_host_i.read_word(1'b0, d, en);
    check_word(d, coded(f));
    dacrp_host_i.read_word(1'b0, d, en);
    check_word(d, coded(s));
    dacrp_host_i.read_word(1'b0, d, en);
    check_word(d, coded(f));
  endtask
  // strobe without chip select leaves bus released and order untouched
  task automatic s_unselected();
    logic [13:0] d, en;
    dacrp_host_i.convert(1'b0, 1'b0);
    dacrp_host_i.read_word(1'b1, d, en);
    check_word(en, 14'h0000);
    dacrp_host_i.read_word(1'b0, d, en);
    check_word(d, coded(input_a_first));
  endtask
  initial begin
    {input_a_first, input_a_second, input_b_first, input_b_second} = '0;
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    s_pair_order(1'b0, 1'b0, 14'h0123, 14'h3abc);
    s_pair_order(1'b1, 1'b1, 14'h3fff, 14'h0000);
    s_pair_order(1'b0, 1'b1, 14'h2000, 14'h1555);
    s_unselected();
    tally_and_finish();
  end
endmodule
